// >>> src/iqc_cfg.svh
// Constants of the IQ gain, phase and delay register bank.
// Assumes inclusion by the package and the modules of this block only.
`ifndef IQC_CFG_SVH
`define IQC_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IQC_IDX_GAIN_A 6'h0C
`define IQC_IDX_GAIN_B 6'h0D
`define IQC_IDX_GAIN_C 6'h0E
`define IQC_IDX_GAIN_D 6'h0F
`define IQC_IDX_PHASE_AB 6'h10
`define IQC_IDX_PHASE_CD 6'h11
`define IQC_IDX_ACT_AB 6'h14
`define IQC_IDX_ACT_CD 6'h15

// ----------------------------------------------------------------
// Staged register slots
// ----------------------------------------------------------------
`define IQC_SLOT_GAIN_A 3'h0
`define IQC_SLOT_GAIN_B 3'h1
`define IQC_SLOT_GAIN_C 3'h2
`define IQC_SLOT_GAIN_D 3'h3
`define IQC_SLOT_PHASE_AB 3'h4
`define IQC_SLOT_PHASE_CD 3'h5
`define IQC_SLOT_ACT_AB 3'h6
`define IQC_SLOT_NONE 3'h7

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define IQC_RST_GAIN 16'h0400
`define IQC_RST_PHASE 16'h0000
`define IQC_MASK_GAIN 16'h07FF
`define IQC_MASK_GAIN_D 16'hF7FF
`define IQC_MASK_PHASE 16'h0FFF

// ----------------------------------------------------------------
// Field positions and scaling
// ----------------------------------------------------------------
`define IQC_GAIN_MSB 10
`define IQC_PHASE_MSB 11
`define IQC_LAG_AB_LSB 14
`define IQC_LAG_CD_LSB 12
`define IQC_GAIN_FRAC 10
`define IQC_PHASE_FRAC 12
`define IQC_GAIN_ALIGN 2

// ----------------------------------------------------------------
// Bus answers and datapath timing
// ----------------------------------------------------------------
`define IQC_RESP_OKAY 2'h0
`define IQC_RESP_SLVERR 2'h2
`define IQC_MAX_LAG 3

`endif

// >>> src/iqc_pkg.sv
// Types of the IQ gain, phase and delay register bank.
// Assumes an AXI4-Lite master with 8-bit addresses and 32-bit data.
`default_nettype none

package iqc_pkg;

  typedef struct packed {
    logic signed [15:0] a;
    logic signed [15:0] b;
    logic signed [15:0] c;
    logic signed [15:0] d;
  } iqc_quad_t;

  typedef struct packed {
    logic [10:0] gain_a;
    logic [10:0] gain_b;
    logic [10:0] gain_c;
    logic [10:0] gain_d;
    logic [11:0] phase_ab;
    logic [11:0] phase_cd;
    logic [1:0] lag_ab;
    logic [1:0] lag_cd;
  } iqc_active_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic [2:0] awprot;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic [2:0] arprot;
    logic rready;
  } iqc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } iqc_axi_rsp_t;

endpackage

`default_nettype wire

// >>> src/iqc_lag_line.sv
// Selectable output lag of zero to DEPTH clock cycles, registered output.
// Assumes the lag select is stable while samples flow.
`timescale 1ns/1ps
`default_nettype none

module iqc_lag_line #(
  parameter int W = 33,
  parameter int DEPTH = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [W-1:0] in_data,
  input wire logic [$clog2(DEPTH+1)-1:0] lag,
  output logic [W-1:0] out_data
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (W < 1 || DEPTH < 1)
  begin : g_size_check
    $error("iqc_lag_line: W and DEPTH must be at least 1");
  end

  logic [W-1:0] tap_q [DEPTH];

  // ----------------------------------------------------------------
  // Tap chain
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tap_q[0] <= '0;
    else if (clk_en)
      tap_q[0] <= in_data;
  end

  for (genvar k = 1; k < DEPTH; k++)
  begin : g_tap
    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
        tap_q[k] <= '0;
      else if (clk_en)
        tap_q[k] <= tap_q[k-1];
    end
  end

  // ----------------------------------------------------------------
  // Tap select
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      out_data <= '0;
    else if (clk_en)
    begin
      if (lag == '0)
        out_data <= in_data;
      else
        out_data <= tap_q[int'(lag) - 1];
    end
  end

endmodule

`default_nettype wire

// >>> src/iqc_regs.sv
// IQ gain, phase and output lag registers with staged and active sets.
// Assumes an AXI4-Lite master on clk and the autosync enable from
// another configuration register on the same clock.
//
// Function
// - Gains C, D: 11-bit unsigned, reset unity
// - Gain binary point between bits 9, 10
// - AB outputs lag 0-3 cycles, bits 15:14
// - CD outputs lag 0-3 cycles, bits 13:12
// - AB phase: 12-bit signed, reset zero
// - B times phase added into A
// - AB phase write raises autosync when enabled
// - Autosync loads A, B gains, phase together
// - Gain A, B writes alone change nothing
// - C, D gains, lags load on CD sync
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "iqc_cfg.svh"

module iqc_regs #(
  parameter int MAX_LAG = `IQC_MAX_LAG
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic corr_autosync_enable,
  input wire iqc_pkg::iqc_axi_req_t axi_req,
  output iqc_pkg::iqc_axi_rsp_t axi_rsp,
  input wire iqc_pkg::iqc_quad_t in_quad,
  input wire logic in_valid,
  output iqc_pkg::iqc_quad_t out_quad,
  output logic out_ab_valid,
  output logic out_cd_valid
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (MAX_LAG != `IQC_MAX_LAG)
  begin : g_lag_check
    $error("iqc_regs: lag field is two bits, MAX_LAG must be 3");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] slot_of(input logic [7:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    case (idx)
      `IQC_IDX_GAIN_A: slot_of = `IQC_SLOT_GAIN_A;
      `IQC_IDX_GAIN_B: slot_of = `IQC_SLOT_GAIN_B;
      `IQC_IDX_GAIN_C: slot_of = `IQC_SLOT_GAIN_C;
      `IQC_IDX_GAIN_D: slot_of = `IQC_SLOT_GAIN_D;
      `IQC_IDX_PHASE_AB: slot_of = `IQC_SLOT_PHASE_AB;
      `IQC_IDX_PHASE_CD: slot_of = `IQC_SLOT_PHASE_CD;
      `IQC_IDX_ACT_AB: slot_of = `IQC_SLOT_ACT_AB;
      default: slot_of = `IQC_SLOT_NONE;
    endcase
  endfunction

  function automatic logic [15:0] mask_of(input logic [2:0] slot);
    case (slot)
      `IQC_SLOT_GAIN_D: mask_of = `IQC_MASK_GAIN_D;
      `IQC_SLOT_PHASE_AB: mask_of = `IQC_MASK_PHASE;
      `IQC_SLOT_PHASE_CD: mask_of = `IQC_MASK_PHASE;
      default: mask_of = `IQC_MASK_GAIN;
    endcase
  endfunction

  // Gain times own sample plus phase times neighbour, saturated
  function automatic logic signed [15:0] correct(
    input logic signed [15:0] own,
    input logic [10:0] gain,
    input logic signed [15:0] nb,
    input logic [11:0] phase
  );
    logic signed [27:0] p_gain;
    logic signed [27:0] p_phase;
    logic signed [30:0] sum;
    logic signed [30:0] scaled;
    p_gain = own * $signed({1'b0, gain});
    p_phase = nb * $signed(phase);
    sum = (31'(p_gain) <<< `IQC_GAIN_ALIGN) + 31'(p_phase);
    scaled = sum >>> `IQC_PHASE_FRAC;
    if (scaled > 31'sh7FFF)
      correct = 16'sh7FFF;
    else if (scaled < -31'sh8000)
      correct = -16'sh8000;
    else
      correct = scaled[15:0];
  endfunction

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic aw_got_q;
  logic w_got_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_take;
  logic w_take;
  logic b_done;
  logic wr_fire;
  logic [2:0] wr_slot;

  assign aw_take = axi_req.awvalid && awready_q;
  assign w_take = axi_req.wvalid && wready_q;
  assign b_done = bvalid_q && axi_req.bready;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign wr_slot = slot_of(awaddr_q);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_got_q <= 1'b0;
      awready_q <= 1'b1;
      awaddr_q <= 8'h00;
    end
    else if (clk_en)
    begin
      if (aw_take)
      begin
        aw_got_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= axi_req.awaddr;
      end
      else if (wr_fire)
        aw_got_q <= 1'b0;
      else if (b_done)
        awready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      w_got_q <= 1'b0;
      wready_q <= 1'b1;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else if (clk_en)
    begin
      if (w_take)
      begin
        w_got_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end
      else if (wr_fire)
        w_got_q <= 1'b0;
      else if (b_done)
        wready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `IQC_RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_slot < `IQC_SLOT_ACT_AB) ? `IQC_RESP_OKAY : `IQC_RESP_SLVERR;
      end
      else if (b_done)
        bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Staged registers
  // ----------------------------------------------------------------
  logic [15:0] stg_q [6];
  logic [15:0] wr_new;

  always_comb
  begin
    wr_new = (wr_slot < `IQC_SLOT_ACT_AB) ? stg_q[wr_slot] : 16'h0000;
    if (wstrb_q[0])
      wr_new[7:0] = wdata_q[7:0];
    if (wstrb_q[1])
      wr_new[15:8] = wdata_q[15:8];
    wr_new = wr_new & mask_of(wr_slot);
  end

  for (genvar s = 0; s < 6; s++)
  begin : g_stage
    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
        stg_q[s] <= (s < 4) ? `IQC_RST_GAIN : `IQC_RST_PHASE;
      else if (clk_en && wr_fire && wr_slot == 3'(s))
        stg_q[s] <= wr_new;
    end
  end

  // ----------------------------------------------------------------
  // Autosync and active settings
  // ----------------------------------------------------------------
  iqc_pkg::iqc_active_t act_q;
  logic sync_ab;
  logic sync_cd;

  assign sync_ab = wr_fire && wr_slot == `IQC_SLOT_PHASE_AB && corr_autosync_enable;
  assign sync_cd = wr_fire && wr_slot == `IQC_SLOT_PHASE_CD && corr_autosync_enable;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      act_q.gain_a <= 11'(`IQC_RST_GAIN);
      act_q.gain_b <= 11'(`IQC_RST_GAIN);
      act_q.phase_ab <= 12'(`IQC_RST_PHASE);
    end
    else if (clk_en && sync_ab)
    begin
      act_q.gain_a <= stg_q[`IQC_SLOT_GAIN_A][`IQC_GAIN_MSB:0];
      act_q.gain_b <= stg_q[`IQC_SLOT_GAIN_B][`IQC_GAIN_MSB:0];
      act_q.phase_ab <= wr_new[`IQC_PHASE_MSB:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      act_q.gain_c <= 11'(`IQC_RST_GAIN);
      act_q.gain_d <= 11'(`IQC_RST_GAIN);
      act_q.phase_cd <= 12'(`IQC_RST_PHASE);
      act_q.lag_ab <= 2'h0;
      act_q.lag_cd <= 2'h0;
    end
    else if (clk_en && sync_cd)
    begin
      act_q.gain_c <= stg_q[`IQC_SLOT_GAIN_C][`IQC_GAIN_MSB:0];
      act_q.gain_d <= stg_q[`IQC_SLOT_GAIN_D][`IQC_GAIN_MSB:0];
      act_q.phase_cd <= wr_new[`IQC_PHASE_MSB:0];
      act_q.lag_ab <= stg_q[`IQC_SLOT_GAIN_D][`IQC_LAG_AB_LSB +: 2];
      act_q.lag_cd <= stg_q[`IQC_SLOT_GAIN_D][`IQC_LAG_CD_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [2:0] rd_slot;
  logic [15:0] rd_word;

  assign rd_slot = slot_of(axi_req.araddr);

  always_comb
  begin
    rd_word = 16'h0000;
    if (rd_slot < `IQC_SLOT_ACT_AB)
      rd_word = stg_q[rd_slot];
    else if (rd_slot == `IQC_SLOT_ACT_AB)
      rd_word = {4'h0, act_q.phase_ab};
    else if (axi_req.araddr[7:2] == `IQC_IDX_ACT_CD)
      rd_word = {act_q.lag_ab, act_q.lag_cd, act_q.phase_cd};
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `IQC_RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (axi_req.arvalid && arready_q)
      begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= {16'h0000, rd_word};
        if (rd_slot != `IQC_SLOT_NONE || axi_req.araddr[7:2] == `IQC_IDX_ACT_CD)
          rresp_q <= `IQC_RESP_OKAY;
        else
          rresp_q <= `IQC_RESP_SLVERR;
      end
      else if (rvalid_q && axi_req.rready)
      begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign axi_rsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q,
                     bresp: bresp_q, arready: arready_q, rvalid: rvalid_q,
                     rdata: rdata_q, rresp: rresp_q};

  // ----------------------------------------------------------------
  // Correction stage
  // ----------------------------------------------------------------
  iqc_pkg::iqc_quad_t corr_q;
  logic corr_v_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      corr_q <= '0;
      corr_v_q <= 1'b0;
    end
    else if (clk_en)
    begin
      corr_q.a <= correct(in_quad.a, act_q.gain_a, in_quad.b, act_q.phase_ab);
      corr_q.b <= correct(in_quad.b, act_q.gain_b, in_quad.b, 12'h000);
      corr_q.c <= correct(in_quad.c, act_q.gain_c, in_quad.d, act_q.phase_cd);
      corr_q.d <= correct(in_quad.d, act_q.gain_d, in_quad.d, 12'h000);
      corr_v_q <= in_valid;
    end
  end

  // ----------------------------------------------------------------
  // Pair output lags
  // ----------------------------------------------------------------
  logic [32:0] ab_out;
  logic [32:0] cd_out;

  iqc_lag_line #(.W(33), .DEPTH(MAX_LAG)) u_lag_ab (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_data({corr_v_q, corr_q.a, corr_q.b}),
    .lag(act_q.lag_ab),
    .out_data(ab_out)
  );

  iqc_lag_line #(.W(33), .DEPTH(MAX_LAG)) u_lag_cd (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_data({corr_v_q, corr_q.c, corr_q.d}),
    .lag(act_q.lag_cd),
    .out_data(cd_out)
  );

  assign out_ab_valid = ab_out[32];
  assign out_quad.a = ab_out[31:16];
  assign out_quad.b = ab_out[15:0];
  assign out_cd_valid = cd_out[32];
  assign out_quad.c = cd_out[31:16];
  assign out_quad.d = cd_out[15:0];

endmodule

`default_nettype wire

// >>> test/iqc_regs_props.sv
// Port assertions of the IQ gain, phase and lag register bank.
// Assumes binding to iqc_regs from the bench top.
`timescale 1ns/1ps
`default_nettype none

module iqc_regs_props #(
  parameter int MAX_LAG = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic corr_autosync_enable,
  input wire iqc_pkg::iqc_axi_req_t axi_req,
  input wire iqc_pkg::iqc_axi_rsp_t axi_rsp,
  input wire iqc_pkg::iqc_quad_t in_quad,
  input wire logic in_valid,
  input wire iqc_pkg::iqc_quad_t out_quad,
  input wire logic out_ab_valid,
  input wire logic out_cd_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_b_hold: assert property (axi_rsp.bvalid && !(axi_req.bready && clk_en) |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write answer dropped early");
  a_r_hold: assert property (axi_rsp.rvalid && !(axi_req.rready && clk_en) |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read answer dropped early");
  a_ar_answer: assert property (axi_req.arvalid && axi_rsp.arready && clk_en |=>
    axi_rsp.rvalid && !axi_rsp.arready) else $error("read not answered");
  a_rd_upper: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_b_blocks: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while answer pending");
  a_wr_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid &&
    axi_rsp.wready && clk_en ##1 clk_en |=> axi_rsp.bvalid) else $error("write not answered");
  a_rd_unmapped: assert property (axi_req.arvalid && axi_rsp.arready && clk_en &&
    !(axi_req.araddr[7:2] inside {6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h14, 6'h15}) |=>
    axi_rsp.rresp == 2'h2 && axi_rsp.rdata == 32'h0) else $error("unmapped read not refused");
  a_clken_hold: assert property (!clk_en |=> $stable(axi_rsp) && $stable(out_quad) &&
    $stable(out_ab_valid) && $stable(out_cd_valid)) else $error("state moved while stalled");
endmodule

`default_nettype wire

// >>> test/iqc_regs_tb.sv
// Self-checking bench of the IQ gain, phase and lag register bank.
// Assumes iqc_pkg, iqc_regs and iqc_regs_props are compiled first.
`timescale 1ns/1ps
`default_nettype none

module iqc_regs_tb;
  typedef struct {logic [15:0] x; logic [15:0] y; int due;} iqc_exp_t;
  logic clk = 1'h0;
  logic reset_n, clk_en, en, iv, abv, cdv;
  logic [11:0] p;
  iqc_pkg::iqc_axi_req_t req;
  iqc_pkg::iqc_axi_rsp_t rsp;
  iqc_pkg::iqc_quad_t qi, qo;
  int failures = 0, comparisons = 0, cyc = 0, seed = 32438;
  longint ga = 1024, gb = 1024, gc = 1024, gd = 1024, pab = 0, pcd = 0, sgc, sgd;
  int lab = 0, lcd = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  iqc_exp_t abq[$], cdq[$];

  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  iqc_regs iqc_regs_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .corr_autosync_enable(en), .axi_req(req), .axi_rsp(rsp), .in_quad(qi),
    .in_valid(iv), .out_quad(qo), .out_ab_valid(abv), .out_cd_valid(cdv));

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic fail(input string m);
    failures++;
    $display("Error at %0t: %s", $time, m);
  endtask

  task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp)
      fail($sformatf("bus got %h exp %h", got, exp));
  endtask

  task automatic cmp_smp(input logic [31:0] got, ref iqc_exp_t q[$]);
    iqc_exp_t e;
    e = '{16'hXXXX, 16'hXXXX, -1};
    if (q.size() > 0)
      e = q.pop_front();
    comparisons++;
    if ({got, cyc} !== {e.x, e.y, e.due})
      fail($sformatf("sample got %h at %0d exp %h%h at %0d", got, cyc, e.x, e.y, e.due));
  endtask

  always @(posedge clk)
  begin
    if (reset_n && clk_en)
    begin
      if (rsp.bvalid && req.bready)
        cmp_bus({32'h0, rsp.bresp}, bq.size() > 0 ? {32'h0, bq.pop_front()} : 'x);
      if (rsp.rvalid && req.rready)
        cmp_bus({rsp.rresp, rsp.rdata}, rq.size() > 0 ? rq.pop_front() : 'x);
      if (abv)
        cmp_smp({qo.a, qo.b}, abq);
      if (cdv)
        cmp_smp({qo.c, qo.d}, cdq);
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  function automatic logic [15:0] cor(longint x, longint g, longint y, longint ph);
    longint v;
    v = (x * g * 4 + y * ph) >>> 12;
    if (v > 32767)
      return 16'h7FFF;
    if (v < -32768)
      return 16'h8000;
    return v[15:0];
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    bq.push_back(er);
    @(posedge clk);
    req.awvalid <= 1'h1;
    req.awaddr <= a;
    req.wvalid <= 1'h1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (rsp.awready && clk_en)
        req.awvalid <= 1'h0;
      if (rsp.wready && clk_en)
        req.wvalid <= 1'h0;
    end
    while (!(rsp.bvalid && clk_en) && n < 50);
    req.bready <= 1'h0;
    if (n >= 50)
    begin
      fail("write timeout");
      final_report();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    rq.push_back({er, d});
    @(posedge clk);
    req.arvalid <= 1'h1;
    req.araddr <= a;
    req.rready <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (rsp.arready && clk_en)
        req.arvalid <= 1'h0;
    end
    while (!(rsp.rvalid && clk_en) && n < 50);
    req.rready <= 1'h0;
    if (n >= 50)
    begin
      fail("read timeout");
      final_report();
    end
  endtask

  task automatic smp();
    logic [63:0] r;
    longint a, b, c, d;
    r = {$random(seed), $random(seed)};
    a = $signed(r[63:48]);
    b = $signed(r[47:32]);
    c = $signed(r[31:16]);
    d = $signed(r[15:0]);
    @(posedge clk);
    qi <= r;
    iv <= 1'h1;
    abq.push_back('{cor(a, ga, b, pab), cor(b, gb, 0, 0), cyc + 3 + lab});
    cdq.push_back('{cor(c, gc, d, pcd), cor(d, gd, 0, 0), cyc + 3 + lcd});
    @(posedge clk);
    iv <= 1'h0;
    qi <= {$random(seed), $random(seed)};
    repeat (8) @(posedge clk);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    reset_n = 1'h0;
    clk_en = 1'h1;
    en = 1'h0;
    iv = 1'h0;
    qi = '0;
    req = '0;
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    for (int i = 0; i < 6; i++)
      rd(8'h30 + 8'(4 * i), i < 4 ? 32'h400 : 32'h0, 2'h0);
    wr(8'h38, 32'hFFFFFFFF, 2'h0);
    rd(8'h38, 32'h7FF, 2'h0);
    wr(8'h3C, 32'hFFFFFFFF, 2'h0);
    rd(8'h3C, 32'hF7FF, 2'h0);
    wr(8'h40, 32'hFFFFFFFF, 2'h0);
    rd(8'h40, 32'hFFF, 2'h0);
    rd(8'h50, 32'h0, 2'h0);
    wr(8'h50, 32'h1, 2'h2);
    wr(8'h04, 32'h1, 2'h2);
    rd(8'h00, 32'h0, 2'h2);
    smp();
    en <= 1'h1;
    wr(8'h30, 32'h200, 2'h0);
    wr(8'h34, 32'h600, 2'h0);
    smp();
    wr(8'h40, 32'h800, 2'h0);
    ga = 512;
    gb = 1536;
    pab = -2048;
    rd(8'h50, 32'h800, 2'h0);
    smp();
    for (int i = 0; i < 4; i++)
    begin
      sgc = $random(seed) & 11'h7FF;
      sgd = $random(seed) & 11'h7FF;
      p = 12'($random(seed));
      wr(8'h38, 32'(sgc), 2'h0);
      wr(8'h3C, {16'h0, 2'(i), 2'(3 - i), 1'h0, 11'(sgd)}, 2'h0);
      smp();
      wr(8'h44, {20'h0, p}, 2'h0);
      gc = sgc;
      gd = sgd;
      pcd = $signed(p);
      lab = i;
      lcd = 3 - i;
      rd(8'h54, {16'h0, 2'(i), 2'(3 - i), p}, 2'h0);
      smp();
    end
    clk_en <= 1'h0;
    fork
      rd(8'h54, {16'h0, 2'h3, 2'h0, p}, 2'h0);
      begin
        repeat (5) @(posedge clk);
        clk_en <= 1'h1;
      end
    join
    repeat (10) @(posedge clk);
    if (abq.size() + cdq.size() + rq.size() + bq.size() > 0)
      fail("results missing");
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail("run timeout");
    final_report();
  end
endmodule

bind iqc_regs iqc_regs_props #(.MAX_LAG(MAX_LAG)) iqc_regs_props_inst (.clk(clk),
  .reset_n(reset_n), .clk_en(clk_en), .corr_autosync_enable(corr_autosync_enable),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .in_quad(in_quad), .in_valid(in_valid),
  .out_quad(out_quad), .out_ab_valid(out_ab_valid), .out_cd_valid(out_cd_valid));

`default_nettype wire
